// >>> sdac_pkg.sv
// Constants, types and helper functions of the converter control block
// Operation
// - Enable bit 0 of mode one: 0 powers converter down, 1 runs conversions.
// - Gain field codes 00, 01, 10 select digital gain x1, x2, x4.
// - Reference level codes 0000..0101 give six rising levels; rest reserved.
// - Reference source bit 7: 1 internal reference, 0 external pin pair.
// - Offset field codes 00..11 add -75%, -50%, -25%, 0% of reference.
// - Decimation codes 000..111 select 64,128,256,1024,4096,8192,16384,32768.
// - Clock codes 000..011 select 250k, 125k, 62.5k, 31.25k converter clock.
// - Word rate spans 3.9 kHz fastest down to 0.95 Hz slowest.
// - Result: gained, offset input over reference, 20-bit signed, saturated.
// - Ready flag set on new result; software clears it, else it stays.
// - First stable result is third word after enable, then every word.
// - Word rate equals converter clock divided by decimation ratio.
// - Result held as 24-bit two's complement in three read-only bytes.
package sdac_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] SDAC_IDX_MODE_ONE = 8'h93;
	localparam logic [7:0] SDAC_IDX_MODE_TWO = 8'h94;
	localparam logic [7:0] SDAC_IDX_MODE_THREE = 8'h95;
	localparam logic [7:0] SDAC_IDX_DATA_HI = 8'h97;
	localparam logic [7:0] SDAC_IDX_DATA_MID = 8'h98;
	localparam logic [7:0] SDAC_IDX_DATA_LO = 8'h99;
	localparam logic [7:0] SDAC_IDX_IRQ_STAT = 8'ha0;
	localparam logic [7:0] SDAC_IDX_IRQ_EN = 8'ha1;
	localparam logic [7:0] SDAC_IDX_IRQ_CLR = 8'ha2;
	localparam logic [7:0] SDAC_MODE_ONE_RST = 8'ha8;
	localparam logic [7:0] SDAC_MODE_TWO_RST = 8'h76;
	localparam logic [7:0] SDAC_MODE_THREE_RST = 8'h10;
	localparam logic [7:0] SDAC_MODE_TWO_MASK = 8'h77;
	localparam logic [7:0] SDAC_MODE_THREE_MASK = 8'h1f;
	localparam int SDAC_ENABLE_BIT = 0;
	localparam int SDAC_GAIN_LSB = 1;
	localparam int SDAC_REF_LVL_LSB = 3;
	localparam int SDAC_REF_SRC_BIT = 7;
	localparam int SDAC_READY_BIT = 0;
	localparam int SDAC_OFFSET_LSB = 1;
	localparam int SDAC_OSR_LSB = 4;
	localparam int SDAC_CLKSEL_LSB = 0;
	localparam int SDAC_IRQ_WORD = 0;
	localparam int SDAC_IRQ_OVERRUN = 1;
	// Converter clock rates, all derived from the 125 MHz bus clock
	localparam int SDAC_SYS_CLK_HZ = 125000000;
	localparam int SDAC_CONV_HZ_0 = 250000;
	localparam int SDAC_CONV_HZ_1 = 125000;
	localparam int SDAC_CONV_HZ_2 = 62500;
	localparam int SDAC_CONV_HZ_3 = 31250;
	localparam logic [11:0] SDAC_DIV_0 = 12'(SDAC_SYS_CLK_HZ / SDAC_CONV_HZ_0);
	localparam logic [11:0] SDAC_DIV_1 = 12'(SDAC_SYS_CLK_HZ / SDAC_CONV_HZ_1);
	localparam logic [11:0] SDAC_DIV_2 = 12'(SDAC_SYS_CLK_HZ / SDAC_CONV_HZ_2);
	localparam logic [11:0] SDAC_DIV_3 = 12'(SDAC_SYS_CLK_HZ / SDAC_CONV_HZ_3);
	localparam logic [1:0] SDAC_SETTLE_LAST = 2'h2;
	// Saturation limits and offsets in 28-bit signed code units
	localparam logic signed [27:0] SDAC_CODE_MAX = 28'h007_ffff;
	localparam logic signed [27:0] SDAC_CODE_MIN = 28'hff8_0000;
	localparam logic signed [27:0] SDAC_OFS_75 = 28'hffa_0000;
	localparam logic signed [27:0] SDAC_OFS_50 = 28'hffc_0000;
	localparam logic signed [27:0] SDAC_OFS_25 = 28'hffe_0000;
	localparam logic signed [27:0] SDAC_OFS_0 = 28'h000_0000;

	typedef enum logic [1:0] {
		SDAC_BUS_IDLE,
		SDAC_BUS_WRITE,
		SDAC_BUS_READ_WAIT,
		SDAC_BUS_READ_DONE
	} sdac_bus_t;

	// Reserved clock codes fall back to the fastest rate
	function automatic logic [11:0] sdac_conv_div(input logic [2:0] sel);
		case (sel)
			3'h1: return SDAC_DIV_1;
			3'h2: return SDAC_DIV_2;
			3'h3: return SDAC_DIV_3;
			default: return SDAC_DIV_0;
		endcase
	endfunction

	function automatic logic [15:0] sdac_osr_len(input logic [2:0] sel);
		case (sel)
			3'h0: return 16'h0040;
			3'h1: return 16'h0080;
			3'h2: return 16'h0100;
			3'h3: return 16'h0400;
			3'h4: return 16'h1000;
			3'h5: return 16'h2000;
			3'h6: return 16'h4000;
			default: return 16'h8000;
		endcase
	endfunction

	function automatic logic [1:0] sdac_gain_shift(input logic [1:0] sel);
		case (sel)
			2'h1: return 2'h1;
			2'h2: return 2'h2;
			default: return 2'h0;
		endcase
	endfunction

	function automatic logic signed [27:0] sdac_offset(input logic [1:0] sel);
		case (sel)
			2'h0: return SDAC_OFS_75;
			2'h1: return SDAC_OFS_50;
			2'h2: return SDAC_OFS_25;
			default: return SDAC_OFS_0;
		endcase
	endfunction
endpackage

// >>> sdac_rate_gen.sv
// Converter clock enable and output word strobe generator
`timescale 1ns/1ps
module sdac_rate_gen
	import sdac_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic run,
	input wire logic [2:0] clk_sel,
	input wire logic [2:0] osr_sel,
	// Strobes
	output logic conv_tick,
	output logic word_tick
);
	logic [11:0] div_cnt;
	logic [15:0] tick_cnt;
	wire logic [11:0] div_lim = sdac_conv_div(clk_sel) - 12'h001;
	wire logic [15:0] osr_lim = sdac_osr_len(osr_sel) - 16'h0001;
	// Compare with >= so a setting change mid-count cannot overrun
	wire logic div_last = div_cnt >= div_lim;
	wire logic tick_last = tick_cnt >= osr_lim;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_cnt <= 12'h000;
			tick_cnt <= 16'h0000;
			conv_tick <= 1'b0;
			word_tick <= 1'b0;
		end
		else if (!run)
		begin
			div_cnt <= 12'h000;
			tick_cnt <= 16'h0000;
			conv_tick <= 1'b0;
			word_tick <= 1'b0;
		end
		else
		begin
			div_cnt <= div_last ? 12'h000 : div_cnt + 12'h001;
			conv_tick <= div_last;
			word_tick <= div_last && tick_last;
			if (div_last)
				tick_cnt <= tick_last ? 16'h0000 : tick_cnt + 16'h0001;
		end
	end

	a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
		conv_tick |=> !conv_tick [*8])
		else $error("converter clock enable too close");
	a_word_on_tick: assert property (@(posedge hclk) disable iff (!hresetn)
		word_tick |-> conv_tick && tick_cnt == 16'h0000)
		else $error("word strobe off the decimation boundary");
	a_osr_fast: assert property (@(posedge hclk) disable iff (!hresetn)
		(word_tick && osr_sel == 3'h0 && $stable(osr_sel)) |-> $past(tick_cnt) == 16'h003f)
		else $error("shortest decimation is not 64 ticks");
endmodule

// >>> sdac_control.sv
// Delta-sigma converter control block with AHB-Lite register slave
`timescale 1ns/1ps
module sdac_control
	import sdac_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Modulator and filter side
	input wire logic [23:0] sample_in,
	output logic conv_power_on,
	output logic conv_clk_tick,
	output logic ref_source_sel,
	output logic [3:0] int_ref_level_sel,
	output logic [1:0] conv_gain_sel,
	output logic [2:0] conv_clock_sel,
	output logic result_ready_flag,
	// Interrupt
	output logic irq
);
	import sdac_pkg::*;

	sdac_bus_t state;
	logic [7:0] a_idx;
	logic [7:0] converter_mode_one;
	logic [7:0] converter_mode_two;
	logic [7:0] converter_mode_three;
	logic [23:0] result;
	logic [1:0] irq_stat;
	logic [1:0] irq_en;
	logic [1:0] settle_cnt;
	logic word_tick;

	// Bus decode; upper address bits alias the block
	wire logic addr_ok = hsel && hready && htrans[1];
	wire logic wr_en = state == SDAC_BUS_WRITE;
	wire logic wr_m1 = wr_en && a_idx == SDAC_IDX_MODE_ONE;
	wire logic wr_m2 = wr_en && a_idx == SDAC_IDX_MODE_TWO;
	wire logic wr_m3 = wr_en && a_idx == SDAC_IDX_MODE_THREE;
	wire logic wr_ien = wr_en && a_idx == SDAC_IDX_IRQ_EN;
	wire logic wr_clr = wr_en && a_idx == SDAC_IDX_IRQ_CLR;
	wire logic [7:0] wbyte = hwdata[7:0];

	// Mode fields
	wire logic conv_enable_bit = converter_mode_one[SDAC_ENABLE_BIT];
	wire logic [1:0] gain_field = converter_mode_one[SDAC_GAIN_LSB +: 2];
	wire logic [1:0] offset_level_sel =
		converter_mode_two[SDAC_OFFSET_LSB +: 2];
	wire logic [2:0] decimation_ratio_sel =
		converter_mode_two[SDAC_OSR_LSB +: 3];
	wire logic ready = converter_mode_two[SDAC_READY_BIT];

	// Result arithmetic: gain shift, offset, saturate to 20 bits
	wire logic [1:0] gain_shift = sdac_gain_shift(gain_field);
	wire logic signed [27:0] offset_val = sdac_offset(offset_level_sel);
	wire logic signed [27:0] sample_ext =
		{{4{sample_in[23]}}, sample_in};
	wire logic signed [27:0] scaled = sample_ext <<< gain_shift;
	wire logic signed [27:0] sum = scaled + offset_val;
	wire logic over = sum > SDAC_CODE_MAX;
	wire logic under = sum < SDAC_CODE_MIN;
	wire logic [19:0] code20 = over ? SDAC_CODE_MAX[19:0] :
		under ? SDAC_CODE_MIN[19:0] : sum[19:0];

	// Only words from the third onward after enable are loaded
	wire logic settled = settle_cnt == SDAC_SETTLE_LAST;
	wire logic load = conv_enable_bit && word_tick && settled;
	wire logic overrun = load && ready;

	// Ready flag: a load in the same cycle as a clear wins
	wire logic next_ready = load || (wr_m2 ? wbyte[SDAC_READY_BIT] : ready);
	wire logic [1:0] clr_bits = wr_clr ? wbyte[1:0] : 2'h0;
	wire logic [1:0] events = {overrun, load};
	wire logic [1:0] next_irq_stat = (irq_stat & ~clr_bits) | events;

	// Read selection
	wire logic [7:0] rd_byte =
		a_idx == SDAC_IDX_MODE_ONE ? converter_mode_one :
		a_idx == SDAC_IDX_MODE_TWO ? converter_mode_two :
		a_idx == SDAC_IDX_MODE_THREE ? converter_mode_three :
		a_idx == SDAC_IDX_DATA_HI ? result[23:16] :
		a_idx == SDAC_IDX_DATA_MID ? result[15:8] :
		a_idx == SDAC_IDX_DATA_LO ? result[7:0] :
		a_idx == SDAC_IDX_IRQ_STAT ? {6'h00, irq_stat} :
		a_idx == SDAC_IDX_IRQ_EN ? {6'h00, irq_en} : 8'h00;

	sdac_rate_gen u_rate (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(conv_enable_bit),
		.clk_sel(converter_mode_three[SDAC_CLKSEL_LSB +: 3]),
		.osr_sel(decimation_ratio_sel),
		.conv_tick(conv_clk_tick),
		.word_tick(word_tick)
	);

	// Reads take one wait state so data always comes from a flip-flop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= SDAC_BUS_IDLE;
			a_idx <= 8'h00;
			hrdata <= 32'h0000_0000;
		end
		else
		begin
			unique case (state)
				SDAC_BUS_READ_WAIT:
				begin
					state <= SDAC_BUS_READ_DONE;
					hrdata <= {24'h00_0000, rd_byte};
				end
				SDAC_BUS_IDLE, SDAC_BUS_WRITE, SDAC_BUS_READ_DONE:
				begin
					if (addr_ok)
					begin
						state <= hwrite ? SDAC_BUS_WRITE : SDAC_BUS_READ_WAIT;
						a_idx <= haddr[9:2];
					end
					else
						state <= SDAC_BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			converter_mode_one <= SDAC_MODE_ONE_RST;
			converter_mode_two <= SDAC_MODE_TWO_RST;
			converter_mode_three <= SDAC_MODE_THREE_RST;
			irq_en <= 2'h0;
		end
		else
		begin
			if (wr_m1)
				converter_mode_one <= wbyte;
			converter_mode_two <= {wbyte[7:1] & SDAC_MODE_TWO_MASK[7:1],
				next_ready};
			if (!wr_m2)
				converter_mode_two[7:1] <= converter_mode_two[7:1];
			if (wr_m3)
				converter_mode_three <= wbyte & SDAC_MODE_THREE_MASK;
			if (wr_ien)
				irq_en <= wbyte[1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			settle_cnt <= 2'h0;
			result <= 24'h00_0000;
			irq_stat <= 2'h0;
		end
		else
		begin
			irq_stat <= next_irq_stat;
			if (!conv_enable_bit)
				settle_cnt <= 2'h0;
			else if (word_tick && !settled)
				settle_cnt <= settle_cnt + 2'h1;
			if (load)
				result <= {code20, 4'h0};
		end
	end

	assign hreadyout = state != SDAC_BUS_READ_WAIT;
	assign hresp = 1'b0;
	assign conv_power_on = conv_enable_bit;
	assign ref_source_sel = converter_mode_one[SDAC_REF_SRC_BIT];
	assign int_ref_level_sel = converter_mode_one[SDAC_REF_LVL_LSB +: 4];
	assign conv_gain_sel = gain_field;
	assign conv_clock_sel = converter_mode_three[SDAC_CLKSEL_LSB +: 3];
	assign result_ready_flag = ready;
	assign irq = |(irq_stat & irq_en);

	a_enable_stops: assert property (@(posedge hclk) disable iff (!hresetn)
		!conv_enable_bit |=> !load && !conv_clk_tick)
		else $error("conversion activity while disabled");
	a_gain_codes: assert property (@(posedge hclk) disable iff (!hresetn)
		scaled == (gain_field == 2'h1 ? sample_ext * 2 :
			gain_field == 2'h2 ? sample_ext * 4 : sample_ext))
		else $error("digital gain mismatch");
	a_gain_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
		gain_field == 2'h3 |-> scaled == sample_ext)
		else $error("reserved gain not x1");
	a_ref_level: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_m1 |=> int_ref_level_sel == $past(hwdata[6:3]))
		else $error("reference level not taken from write");
	a_ref_source: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_m1 |=> ref_source_sel == $past(hwdata[7]))
		else $error("reference source not taken from write");
	a_offset_map: assert property (@(posedge hclk) disable iff (!hresetn)
		(offset_level_sel == 2'h3 |-> sum == scaled) and
		(offset_level_sel == 2'h0 |-> sum == scaled - 28'sd393216))
		else $error("offset level mismatch");
	a_result_sat: assert property (@(posedge hclk) disable iff (!hresetn)
		(load && over) |=> result == 24'h7f_fff0)
		else $error("positive saturation wrong");
	a_result_neg: assert property (@(posedge hclk) disable iff (!hresetn)
		(load && under) |=> result == 24'h80_0000 && result[23])
		else $error("negative saturation wrong");
	a_ready_set: assert property (@(posedge hclk) disable iff (!hresetn)
		load |=> result_ready_flag ##1 (result_ready_flag || $past(wr_m2)))
		else $error("ready flag not set on load");
	a_settle_third: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(conv_enable_bit) |-> !load [*3])
		else $error("result loaded before settling");
	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (@(posedge hclk) disable iff (!hresetn)
		state == SDAC_BUS_WRITE |-> hreadyout)
		else $error("write data phase stalled");
	a_power_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_m1 |=> conv_power_on == $past(hwdata[SDAC_ENABLE_BIT]))
		else $error("enable bit not taken from write");
	a_gain_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_m1 |=> conv_gain_sel == $past(hwdata[2:1]))
		else $error("gain field not taken from write");
	a_offset_mid: assert property (@(posedge hclk) disable iff (!hresetn)
		(offset_level_sel == 2'h1 |-> sum == scaled - 28'sd262144) and
		(offset_level_sel == 2'h2 |-> sum == scaled - 28'sd131072))
		else $error("middle offset level mismatch");
	a_clock_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_m3 |=> conv_clock_sel == $past(hwdata[2:0]))
		else $error("clock field not taken from write");
	a_result_code: assert property (@(posedge hclk) disable iff (!hresetn)
		(load && !over && !under) |=> result == {$past(sum[19:0]), 4'h0})
		else $error("result code not the offset sum");
	a_ready_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(ready && !wr_m2) |=> ready)
		else $error("ready flag dropped without a write");
	a_status_word: assert property (@(posedge hclk) disable iff (!hresetn)
		load |=> irq_stat[SDAC_IRQ_WORD])
		else $error("word status not set on load");
	a_overrun_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		(load && ready) |=> irq_stat[SDAC_IRQ_OVERRUN])
		else $error("overrun not flagged");
	a_irq_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_clr && hwdata[SDAC_IRQ_WORD] && !load) |=>
		!irq_stat[SDAC_IRQ_WORD])
		else $error("word status not cleared");
	a_settle_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		!conv_enable_bit |=> settle_cnt == 2'h0)
		else $error("settling count kept while disabled");
	a_result_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!load |=> $stable(result))
		else $error("result changed without a load");
endmodule

// >>> sdac_front_model.sv
// Behavioural analog front end feeding the converter input code
`timescale 1ns/1ps
module sdac_front_model
#(
	parameter logic UNITY_GAIN = 1'b1
)
(
	// Clock
	input wire logic hclk,
	// Converter controls
	input wire logic conv_power_on,
	input wire logic ref_source_sel,
	// Code in and out
	input wire logic [23:0] target_code,
	output logic [23:0] sample_in,
	// Buffer requests
	output logic signal_buffer_en,
	output logic ref_buffer_en
);
	logic [23:0] idle_code = 24'h00_0000;
	// Unpowered modulator holds no settled code, so toggle every cycle
	always @(posedge hclk)
		idle_code <= ~idle_code;
	assign sample_in = conv_power_on ? target_code : idle_code;
	// Bypassed amplifier needs the input buffer for high impedance
	assign signal_buffer_en = UNITY_GAIN;
	assign ref_buffer_en = !ref_source_sel;
endmodule

// >>> tb_top.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
		end \
	end
module tb_top;
	import sdac_pkg::*;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	wire hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [23:0] sample_in;
	logic [23:0] target_code;
	logic conv_power_on;
	logic conv_clk_tick;
	logic ref_source_sel;
	logic [3:0] int_ref_level_sel;
	logic [1:0] conv_gain_sel;
	logic [2:0] conv_clock_sel;
	logic result_ready_flag;
	logic irq;
	logic signal_buffer_en;
	logic ref_buffer_en;
	logic rd_dphase = 1'b0;
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [31:0] exp_q[$];
	string nm_q[$];
	assign hready = hreadyout;
	sdac_control sdac_control_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sample_in(sample_in), .conv_power_on(conv_power_on),
		.conv_clk_tick(conv_clk_tick), .ref_source_sel(ref_source_sel),
		.int_ref_level_sel(int_ref_level_sel), .conv_gain_sel(conv_gain_sel),
		.conv_clock_sel(conv_clock_sel),
		.result_ready_flag(result_ready_flag), .irq(irq));
	sdac_front_model sdac_front_model_inst (.hclk(hclk),
		.conv_power_on(conv_power_on), .ref_source_sel(ref_source_sel),
		.target_code(target_code), .sample_in(sample_in),
		.signal_buffer_en(signal_buffer_en),
		.ref_buffer_en(ref_buffer_en));
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// Read results are judged here, in the order they were asked for
	always @(posedge hclk)
	begin
		string nm;
		logic [31:0] e;
		if (rd_dphase && hreadyout)
		begin
			nm = nm_q.pop_front();
			e = exp_q.pop_front();
			`CHK(nm, e, hrdata)
			`CHK("hresp", 1'b0, hresp)
		end
		if (hreadyout)
			rd_dphase <= hsel && htrans[1] && !hwrite;
	end
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 125000)
		begin
			fail_count++;
			$display("timeout");
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic addr_phase(input logic [7:0] idx, input logic w);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'b00};
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		addr_phase(idx, 1'b1);
		hwdata <= {24'h0, v};
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] v,
		input string nm);
		exp_q.push_back({24'h0, v});
		nm_q.push_back(nm);
		addr_phase(idx, 1'b0);
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
	endtask
	task automatic tick_gap(input int div);
		int n;
		@(posedge hclk);
		while (conv_clk_tick !== 1'b1)
			@(posedge hclk);
		@(posedge hclk);
		n = 1;
		while (conv_clk_tick !== 1'b1)
		begin
			@(posedge hclk);
			n++;
		end
		`CHK("tick gap", div, n)
	endtask
	initial
	begin
		int s;
		int n;
		logic [7:0] v;
		logic [23:0] r;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		target_code = 24'h00_0000;
		void'($urandom(32'h978c91dd));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		`CHK("ref src", 1'b1, ref_source_sel)
		`CHK("ref lvl", 4'h5, int_ref_level_sel)
		`CHK("power", 1'b0, conv_power_on)
		`CHK("sig buf", 1'b1, signal_buffer_en)
		rd(SDAC_IDX_MODE_ONE, 8'ha8, "mode one rst");
		rd(SDAC_IDX_MODE_TWO, 8'h76, "mode two rst");
		rd(SDAC_IDX_MODE_THREE, 8'h10, "mode three rst");
		rd(SDAC_IDX_DATA_HI, 8'h00, "data hi rst");
		rd(8'h80, 8'h00, "unmapped");
		$display("reset test done");
		for (int i = 0; i < 8; i++)
		begin
			v = 8'($urandom());
			v[2:0] = {i[1:0], 1'b0};
			wr(SDAC_IDX_MODE_ONE, v);
			@(posedge hclk);
			`CHK("gain", i[1:0], conv_gain_sel)
			`CHK("lvl", v[6:3], int_ref_level_sel)
			`CHK("src", v[7], ref_source_sel)
			`CHK("ref buf", !v[7], ref_buffer_en)
			rd(SDAC_IDX_MODE_ONE, v, "mode one");
			v = {1'b0, i[2:0], 1'b0, 2'($urandom()), 1'b0};
			wr(SDAC_IDX_MODE_TWO, v);
			rd(SDAC_IDX_MODE_TWO, v, "mode two");
			wr(SDAC_IDX_MODE_THREE, 8'h10 | 8'(i));
			@(posedge hclk);
			`CHK("clk sel", i[2:0], conv_clock_sel)
		end
		wr(8'h80, 8'hff);
		rd(8'h80, 8'h00, "unmapped wr");
		wr(SDAC_IDX_DATA_LO, 8'hff);
		rd(SDAC_IDX_DATA_LO, 8'h00, "data ro");
		$display("field test done");
		for (int i = 0; i < 4; i++)
		begin
			wr(SDAC_IDX_MODE_THREE, 8'h10 | 8'(i));
			wr(SDAC_IDX_MODE_ONE, 8'h01);
			tick_gap(500 << i);
			wr(SDAC_IDX_MODE_ONE, 8'h00);
		end
		n = 0;
		repeat (600)
		begin
			@(posedge hclk);
			n += (conv_clk_tick === 1'b1);
		end
		`CHK("off ticks", 0, n)
		$display("clock test done");
		s = int'($urandom_range(200000)) - 100000;
		target_code <= 24'(s);
		wr(SDAC_IDX_IRQ_EN, 8'h01);
		wr(SDAC_IDX_MODE_TWO, 8'h04);
		wr(SDAC_IDX_MODE_THREE, 8'h10);
		wr(SDAC_IDX_MODE_ONE, 8'hab);
		n = 0;
		while (result_ready_flag !== 1'b1)
		begin
			@(posedge hclk);
			n++;
		end
		// Three words of 64 ticks of 500 cycles each
		`CHK("settle", 1'b1, n > 95000 && n < 97000)
		`CHK("irq set", 1'b1, irq)
		`CHK("power on", 1'b1, conv_power_on)
		r = 24'((s * 2 - 131072) * 16);
		rd(SDAC_IDX_DATA_HI, r[23:16], "data hi");
		rd(SDAC_IDX_DATA_MID, r[15:8], "data mid");
		rd(SDAC_IDX_DATA_LO, r[7:0], "data lo");
		rd(SDAC_IDX_IRQ_STAT, 8'h01, "status");
		@(posedge hclk);
		`CHK("ready held", 1'b1, result_ready_flag)
		wr(SDAC_IDX_MODE_TWO, 8'h04);
		@(posedge hclk);
		`CHK("ready clr", 1'b0, result_ready_flag)
		wr(SDAC_IDX_IRQ_EN, 8'h00);
		@(posedge hclk);
		`CHK("irq mask", 1'b0, irq)
		wr(SDAC_IDX_IRQ_EN, 8'h01);
		@(posedge hclk);
		`CHK("irq unmask", 1'b1, irq)
		wr(SDAC_IDX_IRQ_CLR, 8'h01);
		@(posedge hclk);
		`CHK("irq clr", 1'b0, irq)
		rd(SDAC_IDX_IRQ_STAT, 8'h00, "status clr");
		$display("conversion test done");
		tally_and_finish();
	end
endmodule
